//--- smbcfg_defines.svh
/*
 Offsets, field positions, reset values and constants of the SMBus configuration target.
 Assumes inclusion by bare name from every design file that needs them.
*/
// Contract
// - Target accepts block read, block write, indexed block read and indexed block write.
// - Plain byte writes are unsupported; a lone data byte is taken as count.
// - Twenty internal registers; only two are writable, the rest reserved.
// - Target answers at 0xAA with strap high and 0xA8 with strap low.
// - Address byte upper six bits 101010, bit 1 strap, bit 0 direction.
// - Block write order: start, address, command, count N, N data bytes, stop.
// - Enable low turns off every function, bandgap included, into standby.
// - Register 0x10 bits 1:0 power state: 01 normal, 10 deep power down, reset 01.
`ifndef SMBCFG_DEFINES_SVH
`define SMBCFG_DEFINES_SVH
`define SMBCFG_NUM_REGS   20
`define SMBCFG_ADDR_HI    6'h2A
`define SMBCFG_REG_TEST   5'h0F
`define SMBCFG_REG_POWER  5'h10
`define SMBCFG_PWR_LSB    0
`define SMBCFG_PWR_NORMAL 2'h1
`define SMBCFG_PWR_DEEP   2'h2
`define SMBCFG_RST_POWER  8'h01
`define SMBCFG_RST_OTHER  8'h00
`define SMBCFG_BITS_BYTE  4'h8
`endif

//--- smbcfg_pkg.sv
/*
 Types shared by the SMBus configuration target.
 Assumes nothing of its surroundings.
*/
package smbcfg_pkg;
    typedef enum logic [3:0] {
        SMBCFG_IDLE   = 4'b0000,
        SMBCFG_ADDR   = 4'b0001,
        SMBCFG_CMD    = 4'b0010,
        SMBCFG_CNT    = 4'b0011,
        SMBCFG_WDATA  = 4'b0100,
        SMBCFG_TX     = 4'b0101,
        SMBCFG_TACK   = 4'b0110,
        SMBCFG_IGNORE = 4'b0111
    } smbcfg_state_t;
endpackage

//--- smbcfg_reg_if.sv
/*
 Carrier between the protocol engine and the register file.
 Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps
interface smbcfg_reg_if;
    logic [4:0] idx;
    logic [7:0] wdata;
    logic       we;
    logic [7:0] rdata;
    logic [1:0] power_state;
    modport engine (output idx, output wdata, output we, input rdata, input power_state);
    modport regs   (input idx, input wdata, input we, output rdata, output power_state);
endinterface

//--- smbcfg_regfile.sv
/*
 Twenty-entry configuration register file in flip-flops.
 Assumes index below the register count and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "smbcfg_defines.svh"
module smbcfg_regfile #(
    parameter int NUM_REGS = `SMBCFG_NUM_REGS
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_srst,
    // Engine side
    smbcfg_reg_if.regs        bus
);
    initial begin
        if (NUM_REGS < 17 || NUM_REGS > 32) begin
            $error("NUM_REGS out of range");
        end
    end

    logic [7:0] regs      [NUM_REGS];
    logic [7:0] next_regs [NUM_REGS];

    function automatic logic user_reg(input logic [4:0] i);
        return (i == `SMBCFG_REG_TEST) || (i == `SMBCFG_REG_POWER);
    endfunction

    always_comb begin
        for (int k = 0; k < NUM_REGS; k++) begin
            next_regs[k] = regs[k];
        end
        // Reserved entries keep their values; internal use only
        if (bus.we && user_reg(bus.idx)) begin
            next_regs[bus.idx] = bus.wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        for (int k = 0; k < NUM_REGS; k++) begin
            if (i_srst) begin
                regs[k] <= (k == `SMBCFG_REG_POWER) ? `SMBCFG_RST_POWER : `SMBCFG_RST_OTHER;
            end else begin
                regs[k] <= next_regs[k];
            end
        end
    end

    assign bus.rdata       = regs[bus.idx];
    assign bus.power_state = regs[`SMBCFG_REG_POWER][`SMBCFG_PWR_LSB +: 2];

    power_reset_a: assert property (@(posedge i_clk) $past(i_srst) |-> bus.power_state == 2'h1)
        else $error("power state not normal after reset");
    reserved_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        bus.we && !user_reg(bus.idx) |-> next_regs[bus.idx] == regs[bus.idx])
        else $error("reserved register changed");
endmodule

//--- smbcfg_target.sv
/*
 SMBus target port of the display-link redriver configuration block.
 Assumes SCL and SDA sampled synchronously to i_clk, which runs far faster than SCL.
*/
`timescale 1ns/1ps
`include "smbcfg_defines.svh"
module smbcfg_target #(
    parameter int NUM_REGS = `SMBCFG_NUM_REGS
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // Device pins
    input  wire logic       i_enable,
    input  wire logic       i_addr_sel,
    // SMBus
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    // Device control
    output logic            o_bandgap_en,
    output logic            o_func_en,
    output logic [1:0]      o_power_state
);
    initial begin
        if (NUM_REGS < 17 || NUM_REGS > 32) begin
            $error("NUM_REGS out of range");
        end
    end

    smbcfg_reg_if rbus ();

    // Standby reset also returns the register file to its reset values
    logic rf_rst;
    assign rf_rst = i_srst || !i_enable;

    smbcfg_regfile #(.NUM_REGS(NUM_REGS)) u_regs (
        .i_clk  (i_clk),
        .i_srst (rf_rst),
        .bus    (rbus.regs)
    );

    smbcfg_pkg::smbcfg_state_t state, next_state;
    logic       scl_q, sda_q, next_scl_q, next_sda_q;
    logic [3:0] bitcnt, next_bitcnt;
    logic [7:0] shreg, next_shreg;
    logic [4:0] idx, next_idx;
    logic [7:0] cnt, next_cnt;
    logic       ack_ph, next_ack_ph;
    logic       rd, next_rd;
    logic       oe, next_oe;
    logic       act, next_act;
    logic       we, next_we;
    logic [7:0] wdata, next_wdata;

    function automatic logic [4:0] inc_idx(input logic [4:0] i);
        return (i == 5'(NUM_REGS - 1)) ? 5'h00 : i + 5'h01;
    endfunction

    logic start, stop, rise, fall, match;
    assign start = i_scl && scl_q && sda_q && !i_sda;
    assign stop  = i_scl && scl_q && !sda_q && i_sda;
    assign rise  = i_scl && !scl_q;
    assign fall  = !i_scl && scl_q;
    assign match = (shreg[7:1] == {`SMBCFG_ADDR_HI, i_addr_sel});

    always_comb begin
        next_state  = state;
        next_scl_q  = i_scl;
        next_sda_q  = i_sda;
        next_bitcnt = bitcnt;
        next_shreg  = shreg;
        next_idx    = idx;
        next_cnt    = cnt;
        next_ack_ph = ack_ph;
        next_rd     = rd;
        next_oe     = oe;
        next_act    = 1'b1;
        next_we     = 1'b0;
        next_wdata  = wdata;
        if (!i_enable) begin
            next_state  = smbcfg_pkg::SMBCFG_IDLE;
            next_oe     = 1'b0;
            next_ack_ph = 1'b0;
            next_act    = 1'b0;
        end else if (start) begin
            next_state  = smbcfg_pkg::SMBCFG_ADDR;
            next_bitcnt = 4'h0;
            next_ack_ph = 1'b0;
            next_oe     = 1'b0;
        end else if (stop) begin
            next_state  = smbcfg_pkg::SMBCFG_IDLE;
            next_ack_ph = 1'b0;
            next_oe     = 1'b0;
        end else begin
            case (state)
                smbcfg_pkg::SMBCFG_ADDR, smbcfg_pkg::SMBCFG_CMD,
                smbcfg_pkg::SMBCFG_CNT, smbcfg_pkg::SMBCFG_WDATA: begin
                    if (rise && !ack_ph && bitcnt != `SMBCFG_BITS_BYTE) begin
                        next_shreg  = {shreg[6:0], i_sda};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (fall && ack_ph) begin
                        // Ack bit ends; release and move on
                        next_ack_ph = 1'b0;
                        next_oe     = 1'b0;
                        next_bitcnt = 4'h0;
                        case (state)
                            smbcfg_pkg::SMBCFG_ADDR: begin
                                if (rd) begin
                                    next_state  = smbcfg_pkg::SMBCFG_TX;
                                    next_shreg  = 8'(NUM_REGS) - {3'h0, idx};
                                    next_oe     = !next_shreg[7];
                                    next_shreg  = {next_shreg[6:0], 1'b0};
                                    next_bitcnt = 4'h1;
                                end else begin
                                    next_state = smbcfg_pkg::SMBCFG_CMD;
                                end
                            end
                            smbcfg_pkg::SMBCFG_CMD:  next_state = smbcfg_pkg::SMBCFG_CNT;
                            smbcfg_pkg::SMBCFG_CNT:  next_state = smbcfg_pkg::SMBCFG_WDATA;
                            default:                 next_state = state;
                        endcase
                    end else if (fall && bitcnt == `SMBCFG_BITS_BYTE) begin
                        next_ack_ph = 1'b1;
                        next_oe     = 1'b1;
                        case (state)
                            smbcfg_pkg::SMBCFG_ADDR: begin
                                if (match) begin
                                    next_rd = shreg[0];
                                end else begin
                                    next_state  = smbcfg_pkg::SMBCFG_IGNORE;
                                    next_ack_ph = 1'b0;
                                    next_oe     = 1'b0;
                                end
                            end
                            smbcfg_pkg::SMBCFG_CMD: begin
                                next_idx = (shreg < 8'(NUM_REGS)) ? shreg[4:0] : 5'h00;
                            end
                            smbcfg_pkg::SMBCFG_CNT: begin
                                // A lone byte lands here as count, so nothing is written
                                next_cnt = shreg;
                            end
                            default: begin
                                if (cnt != 8'h00) begin
                                    next_we    = 1'b1;
                                    next_wdata = shreg;
                                    next_cnt   = cnt - 8'h01;
                                end else begin
                                    next_state  = smbcfg_pkg::SMBCFG_IGNORE;
                                    next_ack_ph = 1'b0;
                                    next_oe     = 1'b0;
                                end
                            end
                        endcase
                    end
                end
                smbcfg_pkg::SMBCFG_TX: begin
                    if (fall) begin
                        if (bitcnt == `SMBCFG_BITS_BYTE) begin
                            next_oe    = 1'b0;
                            next_state = smbcfg_pkg::SMBCFG_TACK;
                        end else begin
                            next_oe     = !shreg[7];
                            next_shreg  = {shreg[6:0], 1'b0};
                            next_bitcnt = bitcnt + 4'h1;
                        end
                    end
                end
                smbcfg_pkg::SMBCFG_TACK: begin
                    if (rise) begin
                        if (!i_sda) begin
                            next_state  = smbcfg_pkg::SMBCFG_TX;
                            next_shreg  = rbus.rdata;
                            next_idx    = inc_idx(idx);
                            next_bitcnt = 4'h0;
                        end else begin
                            next_state = smbcfg_pkg::SMBCFG_IGNORE;
                        end
                    end
                end
                smbcfg_pkg::SMBCFG_IDLE, smbcfg_pkg::SMBCFG_IGNORE: begin
                    next_oe = 1'b0;
                end
                default: begin
                    next_state = smbcfg_pkg::SMBCFG_IDLE;
                    next_oe    = 1'b0;
                end
            endcase
        end
        // Index advances after each data byte within the count, stored or not
        if (we) begin
            next_idx = inc_idx(idx);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state  <= smbcfg_pkg::SMBCFG_IDLE;
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
            bitcnt <= 4'h0;
            shreg  <= 8'h00;
            idx    <= 5'h00;
            cnt    <= 8'h00;
            ack_ph <= 1'b0;
            rd     <= 1'b0;
            oe     <= 1'b0;
            act    <= 1'b0;
            we     <= 1'b0;
            wdata  <= 8'h00;
        end else begin
            state  <= next_state;
            scl_q  <= next_scl_q;
            sda_q  <= next_sda_q;
            bitcnt <= next_bitcnt;
            shreg  <= next_shreg;
            idx    <= next_idx;
            cnt    <= next_cnt;
            ack_ph <= next_ack_ph;
            rd     <= next_rd;
            oe     <= next_oe;
            act    <= next_act;
            we     <= next_we;
            wdata  <= next_wdata;
        end
    end

    assign rbus.idx      = idx;
    assign rbus.we       = we;
    assign rbus.wdata    = wdata;
    // Open drain: only ever pulls low
    assign o_sda_out     = 1'b0;
    assign o_sda_oe      = oe;
    assign o_bandgap_en  = act;
    assign o_func_en     = act;
    assign o_power_state = rbus.power_state;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence addr_done_s;
        state == smbcfg_pkg::SMBCFG_ADDR && fall && !ack_ph && bitcnt == `SMBCFG_BITS_BYTE && i_enable && !start && !stop;
    endsequence
    // Ack in progress with no SCL fall yet to end it
    sequence ack_held_s;
        ack_ph && o_sda_oe && !fall && i_enable && !start && !stop;
    endsequence

    addr_ack_a: assert property (addr_done_s ##0 match |=> o_sda_oe && ack_ph)
        else $error("matching address not acknowledged");
    addr_reject_a: assert property (addr_done_s ##0 (shreg[7:2] != `SMBCFG_ADDR_HI)
        |=> state == smbcfg_pkg::SMBCFG_IGNORE && !o_sda_oe)
        else $error("foreign address acknowledged");
    write_guard_a: assert property (we |-> $past(state) == smbcfg_pkg::SMBCFG_WDATA && $past(cnt) != 8'h00)
        else $error("write without block count");
    write_order_a: assert property (state == smbcfg_pkg::SMBCFG_WDATA && $past(state) != smbcfg_pkg::SMBCFG_WDATA
        |-> $past(state) == smbcfg_pkg::SMBCFG_CNT)
        else $error("data phase not after count");
    index_step_a: assert property (we && i_enable |=> idx == inc_idx($past(idx)))
        else $error("index did not advance");
    read_next_a: assert property (state == smbcfg_pkg::SMBCFG_TACK && rise && !i_sda && i_enable && !start && !stop
        |=> state == smbcfg_pkg::SMBCFG_TX && bitcnt == 4'h0 ##1 state == smbcfg_pkg::SMBCFG_TX && !o_sda_oe)
        else $error("read did not continue after host ack");
    standby_off_a: assert property (!i_enable |=> !o_bandgap_en && !o_func_en && !o_sda_oe
        && state == smbcfg_pkg::SMBCFG_IDLE)
        else $error("functions alive in standby");
    power_map_a: assert property (o_power_state == u_regs.regs[`SMBCFG_REG_POWER][1:0])
        else $error("power state output mismatch");
    ack_hold_a: assert property (ack_held_s |=> o_sda_oe)
        else $error("ack released before SCL fall");
endmodule

//--- smbcfg_host.sv
/*
 Behavioural SMBus host that drives the configuration target's bus pins.
 Assumes a pulled-up SDA wire resolved by the bench, and SCL phases of five clocks.
*/
`timescale 1ns/1ps
module smbcfg_host (
    // Clock
    input  wire logic i_clk,
    // Bus
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    // Change just after an edge, then hold five clocks
    task automatic drive(input logic scl, input logic low);
        @(posedge i_clk);
        o_scl     <= scl;
        o_sda_low <= low;
        repeat (4) @(posedge i_clk);
    endtask

    // Releases SDA with SCL low first, so a repeated start is seen too
    task automatic start_cond();
        drive(1'b0, 1'b0);
        drive(1'b1, 1'b0);
        drive(1'b1, 1'b1);
        drive(1'b0, 1'b1);
    endtask

    task automatic stop_cond();
        drive(1'b0, 1'b1);
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
    endtask

    // Sampled late in the high phase, well after the target settles
    task automatic bit_io(input logic b, output logic seen);
        drive(1'b0, !b);
        drive(1'b1, !b);
        seen = i_sda;
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask

    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(!ack, s);
    endtask
endmodule

//--- tb.sv
/*
 Self-checking bench for the SMBus configuration target.
 Assumes the host model drives the bus and a pull-up resolves SDA.
*/
`timescale 1ns/1ps
module tb;
    logic        i_clk;
    logic        i_srst;
    logic        i_enable;
    logic        i_addr_sel;
    logic        scl;
    logic        host_low;
    logic        sda_wire;
    logic        o_sda_out;
    logic        o_sda_oe;
    logic        o_bandgap_en;
    logic        o_func_en;
    logic [1:0]  o_power_state;
    logic [7:0]  exp_reg [20];
    logic [31:0] rnd;
    logic [7:0]  a;
    logic [7:0]  d1;
    logic        sel;
    int          num_errors;
    int          samples_checked;

    // Pull-up: line low only while someone pulls
    assign sda_wire = (o_sda_oe ? o_sda_out : 1'b1) & !host_low;

    smbcfg_target #(.NUM_REGS(20)) dut (
        .i_clk         (i_clk),
        .i_srst        (i_srst),
        .i_enable      (i_enable),
        .i_addr_sel    (i_addr_sel),
        .i_scl         (scl),
        .i_sda         (sda_wire),
        .o_sda_out     (o_sda_out),
        .o_sda_oe      (o_sda_oe),
        .o_bandgap_en  (o_bandgap_en),
        .o_func_en     (o_func_en),
        .o_power_state (o_power_state)
    );

    smbcfg_host host (
        .i_clk     (i_clk),
        .i_sda     (sda_wire),
        .o_scl     (scl),
        .o_sda_low (host_low)
    );

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [7:0] addr_byte(input logic s, input logic rd);
        return {6'h2A, s, rd};
    endfunction

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Whole write transaction; bytes from n_ack on must be refused
    task automatic send(input logic [7:0] q[$], input int n_ack);
        logic ack;
        host.start_cond();
        foreach (q[k]) begin
            host.put_byte(q[k], ack);
            chk8("ack", {7'h0, k < n_ack}, {7'h0, ack});
        end
        host.stop_cond();
    endtask

    // Command, repeated start, count byte, then every register to the end
    task automatic rd(input logic [4:0] cmd);
        logic       ack;
        logic [7:0] d;
        int         cnt;
        host.start_cond();
        host.put_byte(addr_byte(i_addr_sel, 1'b0), ack);
        host.put_byte({3'h0, cmd}, ack);
        host.start_cond();
        host.put_byte(addr_byte(i_addr_sel, 1'b1), ack);
        chk8("read addr ack", 8'h01, {7'h0, ack});
        host.get_byte(1'b1, d);
        cnt = 20 - cmd;
        chk8("read count", 8'(cnt), d);
        for (int k = 0; k < cnt; k++) begin
            host.get_byte(k < cnt - 1, d);
            chk8("read data", exp_reg[(cmd + k) % 20], d);
        end
        host.stop_cond();
    endtask

    initial begin
        repeat (60000) @(posedge i_clk);
        num_errors++;
        $display("[FAIL] watchdog expected done seen hang");
        print_verdict();
    end

    initial begin
        num_errors      = 0;
        samples_checked = 0;
        rnd             = 32'h108c_699b;
        i_srst          = 1'b1;
        i_enable        = 1'b1;
        i_addr_sel      = 1'b1;
        foreach (exp_reg[k]) exp_reg[k] = 8'h00;
        exp_reg[16] = 8'h01;
        repeat (11) @(posedge i_clk);
        chk8("bandgap in reset", 8'h00, {7'h0, o_bandgap_en});
        chk8("power reset", 8'h01, {6'h0, o_power_state});
        chk8("sda out", 8'h00, {7'h0, o_sda_out});
        @(posedge i_clk);
        i_srst <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk8("func enable", 8'h01, {7'h0, o_func_en});
        // Corner strap and address pairs first, then random ones
        for (int n = 0; n < 8; n++) begin
            rnd = lfsr_next(rnd);
            a   = {rnd[7:1], 1'b0};
            sel = rnd[8];
            if (n < 4) begin
                a   = n[0] ? 8'hA8 : 8'hAA;
                sel = n[0] ^ !n[1];
            end
            @(posedge i_clk);
            i_addr_sel <= sel;
            send({a}, (a[7:1] === {6'h2A, sel}) ? 1 : 0);
        end
        @(posedge i_clk);
        i_addr_sel <= 1'b1;
        send({8'hAA, 8'h10, 8'h01, 8'h02}, 4);
        chk8("deep power down", 8'h02, {6'h0, o_power_state});
        // Lone byte is a count, so nothing may change
        send({8'hAA, 8'h10, 8'h01}, 3);
        chk8("byte write ignored", 8'h02, {6'h0, o_power_state});
        rnd = lfsr_next(rnd);
        d1  = rnd[7:0] & 8'h07;
        // Reserved, user, user, then one byte past the count
        send({8'hAA, 8'h0E, 8'h03, 8'h5A, d1, 8'h01, 8'h33}, 6);
        exp_reg[15] = d1;
        chk8("normal power", 8'h01, {6'h0, o_power_state});
        rd(5'h0E);
        rd(5'h00);
        @(posedge i_clk);
        i_addr_sel <= 1'b0;
        send({8'hA8, 8'h10, 8'h01, 8'h02}, 4);
        exp_reg[16] = 8'h02;
        rd(5'h10);
        @(posedge i_clk);
        i_enable <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk8("bandgap off", 8'h00, {7'h0, o_bandgap_en});
        chk8("functions off", 8'h00, {7'h0, o_func_en});
        chk8("standby sda", 8'h00, {7'h0, o_sda_oe});
        chk8("standby power", 8'h01, {6'h0, o_power_state});
        exp_reg[15] = 8'h00;
        exp_reg[16] = 8'h01;
        @(posedge i_clk);
        i_enable <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk8("bandgap back", 8'h01, {7'h0, o_bandgap_en});
        rd(5'h0F);
        print_verdict();
    end
endmodule
